// >>> verilog/irq_regs_pkg.sv
`default_nettype none
package irq_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus carrier types
    typedef logic [31:0] word_type;
    typedef logic [1:0] htrans_type;
    typedef logic [2:0] hsize_type;
    typedef logic [3:0] master_type;

    ////////////////////////////////////////////////////////////////////////////
    // register bank byte offsets
    localparam logic [11:0] FWD_ENABLE_BASE = 12'h100;
    localparam logic [11:0] FWD_DISABLE_BASE = 12'h180;
    localparam logic [11:0] PEND_ASSERT_BASE = 12'h200;

    // field positions inside a byte address
    localparam int BANK_LSB = 7;
    localparam int INDEX_LSB = 2;
    localparam logic [4:0] BANK_FWD_ENABLE = FWD_ENABLE_BASE[11:7];
    localparam logic [4:0] BANK_FWD_DISABLE = FWD_DISABLE_BASE[11:7];
    localparam logic [4:0] BANK_PEND_ASSERT = PEND_ASSERT_BASE[11:7];

    ////////////////////////////////////////////////////////////////////////////
    // interrupt id layout
    localparam int IDS_PER_REG = 32;
    localparam int SGI_COUNT = 16;
    localparam int PPI_COUNT = 16;
    localparam int SPI_FIRST_ID = 32;
    localparam int IT_LINES_DEFAULT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // bus codes and values after reset
    localparam hsize_type HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic READY_RST = 1'b1;
    localparam word_type RDATA_RST = 32'h0000_0000;
    localparam logic [15:0] SGI_ALL_ON = 16'hFFFF;

endpackage
`default_nettype wire

// >>> verilog/irq_line_sync.sv
`timescale 1ns/1ps
`default_nettype none
module irq_line_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] lines_i,
    output logic [WIDTH-1:0] edge_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_state_type;

    sync_state_type st;
    sync_state_type next_st;

    if (WIDTH < 1) begin : g_bad_width
        $error("irq_line_sync needs at least one line");
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser then a delay stage for edge detection
    always_comb begin
        next_st = st;
        next_st.meta = lines_i;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // rising edge, one cycle wide
    assign edge_o = st.sync & ~st.prev;

endmodule // irq_line_sync
`default_nettype wire

// >>> verilog/irq_enable_pending_regs.sv
`timescale 1ns/1ps
`default_nettype none
module irq_enable_pending_regs #(
    parameter int IT_LINES = irq_regs_pkg::IT_LINES_DEFAULT,
    parameter int NUM_CPU = 2,
    parameter int NUM_SPI = 32,
    parameter int LOCK_SPI = 8,
    parameter logic [15:0] PPI_IMPL = 16'hFFFF,
    parameter bit SECURITY = 1'b1,
    parameter bit LOCKDOWN = 1'b1
) (
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic HSEL_I,
    input wire irq_regs_pkg::word_type HADDR_I,
    input wire irq_regs_pkg::htrans_type HTRANS_I,
    input wire logic HWRITE_I,
    input wire irq_regs_pkg::hsize_type HSIZE_I,
    input wire irq_regs_pkg::word_type HWDATA_I,
    input wire logic HREADY_I,
    input wire irq_regs_pkg::master_type HMASTER_I,
    input wire logic HNONSEC_I,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output irq_regs_pkg::word_type HRDATA_O,
    input wire logic [32*(IT_LINES+1)-1:0] GROUP_I,
    input wire logic LOCK_I,
    input wire logic [NUM_CPU*16-1:0] SGI_PEND_I,
    input wire logic [NUM_CPU*16-1:0] PPI_LINE_I,
    input wire logic [NUM_CPU*16-1:0] PPI_ACK_I,
    input wire logic [NUM_CPU*16-1:0] PPI_EOI_I,
    input wire logic [NUM_SPI-1:0] SPI_LINE_I,
    input wire logic [NUM_SPI-1:0] SPI_ACK_I,
    input wire logic [NUM_SPI-1:0] SPI_EOI_I,
    output logic [NUM_CPU*16-1:0] FWD_PPI_O,
    output logic [NUM_SPI-1:0] FWD_SPI_O
);
    import irq_regs_pkg::*;

    localparam int NUM_ID = IDS_PER_REG * (IT_LINES + 1);
    localparam int NPPI = NUM_CPU * PPI_COUNT;
    localparam int CPU_W = $clog2(NUM_CPU);

    if (IT_LINES < 1 || IT_LINES > 31 || NUM_SPI < 1 || NUM_SPI > IDS_PER_REG * IT_LINES ||
        NUM_CPU < 2 || NUM_CPU > 16 || LOCK_SPI < 0 || LOCK_SPI > NUM_SPI) begin : g_bad_param
        $error("irq_enable_pending_regs parameters out of range");
    end

    typedef struct packed {
        logic [NPPI-1:0] ppi_en;
        logic [NPPI-1:0] ppi_pend;
        logic [NPPI-1:0] ppi_act;
        logic [NUM_SPI-1:0] spi_en;
        logic [NUM_SPI-1:0] spi_pend;
        logic [NUM_SPI-1:0] spi_act;
        logic dphase;
        logic dwrite;
        logic dword;
        logic [11:0] daddr;
        logic [CPU_W-1:0] dcpu;
        logic dcpu_ok;
        logic dnonsec;
        word_type hrdata;
        logic hreadyout;
        logic hresp;
        logic [NPPI-1:0] fwd_ppi;
        logic [NUM_SPI-1:0] fwd_spi;
    } state_type;

    state_type st;
    state_type next_st;

    logic [NUM_ID-1:0] impl_mask;
    logic [NUM_ID-1:0] lock_mask;
    logic [NUM_ID-1:0] ok_vec;
    logic [NUM_ID-1:0] lk_vec;
    logic [NUM_ID-1:0] en_vec;
    logic [NUM_ID-1:0] pd_vec;
    logic [IT_LINES:0] dis_hit;
    logic [IT_LINES:0] en_hit;
    logic [IT_LINES:0] pnd_hit;
    logic [NUM_SPI-1:0] spi_clr;
    logic [NUM_SPI-1:0] spi_set;
    logic [NUM_SPI-1:0] spi_pset;
    logic [NPPI-1:0] ppi_clr;
    logic [NPPI-1:0] ppi_set;
    logic [NPPI-1:0] ppi_pset;
    logic [NPPI-1:0] ppi_edge;
    logic [NUM_SPI-1:0] spi_edge;
    logic [NPPI+NUM_SPI-1:0] all_edge;
    logic [4:0] bank;
    logic [4:0] widx;
    logic acc;
    logic wr;
    logic wbit;
    logic [15:0] sgi_view;
    word_type rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // fixed per-id attributes: implemented and lockable
    for (genvar i = 0; i < NUM_ID; i++) begin : g_attr
        if (i < SGI_COUNT) begin : g_sgi
            assign impl_mask[i] = 1'b1;
            assign lock_mask[i] = 1'b0;
        end else if (i < SPI_FIRST_ID) begin : g_ppi
            assign impl_mask[i] = PPI_IMPL[i-SGI_COUNT];
            assign lock_mask[i] = 1'b0;
        end else begin : g_spi
            assign impl_mask[i] = (i - SPI_FIRST_ID) < NUM_SPI;
            assign lock_mask[i] = (i - SPI_FIRST_ID) < LOCK_SPI;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peripheral lines come from outside, synchronised before use
    irq_line_sync #(
        .WIDTH(NPPI + NUM_SPI)
    ) u_line_sync (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .lines_i({SPI_LINE_I, PPI_LINE_I}),
        .edge_o(all_edge)
    );

    assign ppi_edge = all_edge[NPPI-1:0];
    assign spi_edge = all_edge[NPPI+NUM_SPI-1:NPPI];

    ////////////////////////////////////////////////////////////////////////////
    // next state: access filter, decode, bit updates, bus handshake
    always_comb begin
        next_st = st;
        ok_vec = '0;
        lk_vec = '0;
        en_vec = '0;
        pd_vec = '0;
        dis_hit = '0;
        en_hit = '0;
        pnd_hit = '0;
        spi_clr = '0;
        spi_set = '0;
        spi_pset = '0;
        ppi_clr = '0;
        ppi_set = '0;
        ppi_pset = '0;
        rd_word = RDATA_RST;
        wbit = 1'b0;
        bank = st.daddr[11:BANK_LSB];
        widx = st.daddr[BANK_LSB-1:INDEX_LSB];
        sgi_view = SGI_PEND_I[int'(st.dcpu)*SGI_COUNT +: SGI_COUNT];

        // per-bit filter, one common register for both worlds
        for (int i = 0; i < NUM_ID; i++) begin
            ok_vec[i] = impl_mask[i] && !(SECURITY && st.dnonsec && !GROUP_I[i]) &&
                        (i >= SPI_FIRST_ID || st.dcpu_ok);
            lk_vec[i] = LOCKDOWN && LOCK_I && lock_mask[i] && !GROUP_I[i];
        end

        // view of bank zero for the accessing processor
        for (int i = 0; i < SGI_COUNT; i++) begin
            en_vec[i] = 1'b1;
            pd_vec[i] = sgi_view[i];
        end
        for (int i = 0; i < PPI_COUNT; i++) begin
            en_vec[SGI_COUNT+i] = st.ppi_en[int'(st.dcpu)*PPI_COUNT+i];
            pd_vec[SGI_COUNT+i] = st.ppi_pend[int'(st.dcpu)*PPI_COUNT+i];
        end
        for (int s = 0; s < NUM_SPI; s++) begin
            en_vec[SPI_FIRST_ID+s] = st.spi_en[s];
            pd_vec[SPI_FIRST_ID+s] = st.spi_pend[s];
        end

        // decode of the transfer held in its data phase
        acc = st.dphase && st.daddr[1:0] == 2'b00 && int'(widx) <= IT_LINES;
        wr = acc && st.dwrite && st.dword;
        for (int n = 0; n <= IT_LINES; n++) begin
            if (int'(widx) == n) begin
                dis_hit[n] = wr && bank == BANK_FWD_DISABLE;
                en_hit[n] = wr && bank == BANK_FWD_ENABLE;
                pnd_hit[n] = wr && bank == BANK_PEND_ASSERT;
            end
        end

        // read word, no state touched
        if (acc && !st.dwrite) begin
            for (int b = 0; b < IDS_PER_REG; b++) begin
                if (bank == BANK_FWD_DISABLE || bank == BANK_FWD_ENABLE) begin
                    rd_word[b] = en_vec[int'(widx)*IDS_PER_REG+b] && ok_vec[int'(widx)*IDS_PER_REG+b];
                end else if (bank == BANK_PEND_ASSERT) begin
                    rd_word[b] = pd_vec[int'(widx)*IDS_PER_REG+b] && ok_vec[int'(widx)*IDS_PER_REG+b];
                end
            end
        end

        // shared interrupt write masks, locked bits skipped
        for (int s = 0; s < NUM_SPI; s++) begin
            wbit = HWDATA_I[s%IDS_PER_REG] && ok_vec[SPI_FIRST_ID+s] && !lk_vec[SPI_FIRST_ID+s];
            spi_clr[s] = dis_hit[(s+SPI_FIRST_ID)/IDS_PER_REG] && wbit;
            spi_set[s] = en_hit[(s+SPI_FIRST_ID)/IDS_PER_REG] && wbit;
            spi_pset[s] = pnd_hit[(s+SPI_FIRST_ID)/IDS_PER_REG] && wbit;
        end

        // private interrupt write masks, only the accessing processor's copy
        for (int c = 0; c < NUM_CPU; c++) begin
            for (int i = 0; i < PPI_COUNT; i++) begin
                wbit = HWDATA_I[SGI_COUNT+i] && ok_vec[SGI_COUNT+i] && int'(st.dcpu) == c;
                ppi_clr[c*PPI_COUNT+i] = dis_hit[0] && wbit;
                ppi_set[c*PPI_COUNT+i] = en_hit[0] && wbit;
                ppi_pset[c*PPI_COUNT+i] = pnd_hit[0] && wbit;
            end
        end

        // enable state, clear stays until a later set
        next_st.spi_en = (st.spi_en | spi_set) & ~spi_clr;
        next_st.ppi_en = (st.ppi_en | ppi_set) & ~ppi_clr;

        // pending and active, independent of enable; set wins over ack
        next_st.spi_pend = (st.spi_pend & ~SPI_ACK_I) | spi_edge | spi_pset;
        next_st.spi_act = (st.spi_act & ~SPI_EOI_I) | (SPI_ACK_I & st.spi_pend);
        next_st.ppi_pend = (st.ppi_pend & ~PPI_ACK_I) | ppi_edge | ppi_pset;
        next_st.ppi_act = (st.ppi_act & ~PPI_EOI_I) | (PPI_ACK_I & st.ppi_pend);

        // enable only gates delivery
        next_st.fwd_spi = next_st.spi_en & next_st.spi_pend;
        next_st.fwd_ppi = next_st.ppi_en & next_st.ppi_pend;

        // bus: address phase, then one wait cycle, then ready with data
        next_st.hresp = HRESP_OKAY;
        if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
            next_st.dphase = 1'b1;
            next_st.dwrite = HWRITE_I;
            next_st.dword = HSIZE_I == HSIZE_WORD;
            next_st.daddr = HADDR_I[11:0];
            next_st.dcpu = HMASTER_I[CPU_W-1:0];
            next_st.dcpu_ok = int'(HMASTER_I) < NUM_CPU;
            next_st.dnonsec = HNONSEC_I;
            next_st.hreadyout = 1'b0;
        end else if (st.dphase) begin
            next_st.dphase = 1'b0;
            next_st.hreadyout = 1'b1;
            next_st.hrdata = rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            st <= '0;
            st.hreadyout <= READY_RST;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign HREADYOUT_O = st.hreadyout;
    assign HRESP_O = st.hresp;
    assign HRDATA_O = st.hrdata;
    assign FWD_PPI_O = st.fwd_ppi;
    assign FWD_SPI_O = st.fwd_spi;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_addr_phase;
        HSEL_I && HREADY_I && HTRANS_I[1];
    endsequence

    sequence s_data_phase;
        !HREADYOUT_O ##1 HREADYOUT_O;
    endsequence

    a_bus_timing: assert property (s_addr_phase |=> s_data_phase)
        else $error("transfer did not finish after one wait cycle");

    a_clear_stops_fwd: assert property (wr && bank == BANK_FWD_DISABLE && widx == 5'h01 &&
        !st.dnonsec && !LOCK_I && HWDATA_I[0] |=> (!st.spi_en[0] && !FWD_SPI_O[0]) [*2])
        else $error("clear-enable write left forwarding on");

    a_zero_no_effect: assert property (wr && bank == BANK_FWD_DISABLE |=>
        (st.spi_en & ~$past(st.spi_en)) == '0)
        else $error("clear-enable write raised an enable bit");

    a_read_state: assert property (acc && !st.dwrite && bank == BANK_FWD_DISABLE && widx == 5'h01 &&
        !st.dnonsec |=> HRDATA_O[0] == $past(st.spi_en[0]))
        else $error("clear-enable read does not show enable state");

    a_unimpl_raz: assert property (st.dphase && !st.dwrite && int'(widx) > IT_LINES |=>
        HRDATA_O == RDATA_RST)
        else $error("unimplemented register read not zero");

    a_nonsec_hidden: assert property (SECURITY && acc && !st.dwrite && st.dnonsec &&
        bank == BANK_FWD_DISABLE && widx == 5'h01 && !GROUP_I[SPI_FIRST_ID+2] |=> !HRDATA_O[2])
        else $error("group 0 bit visible to non-secure read");

    a_lock_enable: assert property (LOCKDOWN && LOCK_SPI > 2 && wr && bank == BANK_FWD_DISABLE &&
        widx == 5'h01 && LOCK_I && !GROUP_I[SPI_FIRST_ID+2] |=> st.spi_en[2] == $past(st.spi_en[2]))
        else $error("locked enable bit was modified");

    a_lock_pend: assert property (LOCKDOWN && LOCK_SPI > 2 && wr && bank == BANK_PEND_ASSERT &&
        widx == 5'h01 && LOCK_I && !GROUP_I[SPI_FIRST_ID+2] && !st.spi_pend[2] && !spi_edge[2] |=>
        !st.spi_pend[2])
        else $error("locked pending bit was set");

    a_sgi_enabled: assert property (acc && !st.dwrite && bank == BANK_FWD_DISABLE && widx == 5'h00 &&
        !st.dnonsec && st.dcpu_ok |=> HRDATA_O[15:0] == SGI_ALL_ON)
        else $error("software interrupt enable not fixed on");

    a_sgi_pend_ro: assert property (acc && !st.dwrite && bank == BANK_PEND_ASSERT && widx == 5'h00 &&
        !st.dnonsec && st.dcpu_ok |=> HRDATA_O[15:0] == $past(sgi_view))
        else $error("software interrupt pending read wrong");

    a_pend_while_off: assert property (spi_edge[0] |=> st.spi_pend[0] && FWD_SPI_O[0] == st.spi_en[0])
        else $error("edge did not pend the interrupt");

    a_set_pending: assert property (wr && bank == BANK_PEND_ASSERT && widx == 5'h01 && !st.dnonsec &&
        !LOCK_I && HWDATA_I[0] |=> st.spi_pend[0] && st.spi_act[0] == ($past(st.spi_act[0]) ||
        $past(SPI_ACK_I[0] && st.spi_pend[0])) && !$past(SPI_EOI_I[0]) || $past(SPI_EOI_I[0]))
        else $error("set-pending write failed");

    a_bank_separate: assert property (wr && bank == BANK_FWD_DISABLE && widx == 5'h00 &&
        st.dcpu == '0 |=> st.ppi_en[2*PPI_COUNT-1:PPI_COUNT] == $past(st.ppi_en[2*PPI_COUNT-1:PPI_COUNT]))
        else $error("write reached another processor's bank");

endmodule // irq_enable_pending_regs
`default_nettype wire

// >>> tb/cpu_if_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_if_model #(
    parameter int W = 32,
    parameter int EOI_DELAY = 40
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic accept_i,
    input wire logic [W-1:0] fwd_i,
    output logic [W-1:0] ack_o,
    output logic [W-1:0] eoi_o
);
    logic [W-1:0] active;
    logic [W-1:0] lowest;
    int cnt;

    ////////////////////////////////////////////////////////////////////////////
    // one interrupt handled at a time, lowest forwarded line first
    assign lowest = fwd_i & (~fwd_i + 1'b1);

    // accept only while allowed; end of handling comes after a slow delay
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            active <= '0;
            ack_o <= '0;
            eoi_o <= '0;
            cnt <= 0;
        end else begin
            ack_o <= '0;
            eoi_o <= '0;
            if (active == '0 && accept_i && fwd_i != '0) begin
                ack_o <= lowest;
                active <= lowest;
                cnt <= EOI_DELAY;
            end else if (active != '0) begin
                if (cnt == 0) begin
                    eoi_o <= active; // handler done
                    active <= '0;
                end else begin
                    cnt <= cnt - 1;
                end
            end
        end
    end
endmodule // cpu_if_model
`default_nettype wire

// >>> tb/irq_enable_pending_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module irq_enable_pending_regs_tb;
    import irq_regs_pkg::*;
    logic clk = 1'b0;
    logic rst, hsel, hwrite, hnonsec, lock, hreadyout, hresp, ppi_acc, spi_acc;
    word_type haddr, hwdata, hrdata, fwd_ppi, fwd_spi, ppi_line, ppi_ack, ppi_eoi;
    word_type spi_line, spi_ack, spi_eoi, sgi_pend, rd;
    htrans_type htrans;
    hsize_type hsize;
    master_type hmaster;
    logic [63:0] group;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////////
    // clock, device and far-side models
    always #2 clk = ~clk;

    irq_enable_pending_regs i_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hreadyout),
        .HMASTER_I(hmaster), .HNONSEC_I(hnonsec), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
        .HRDATA_O(hrdata), .GROUP_I(group), .LOCK_I(lock), .SGI_PEND_I(sgi_pend), .PPI_LINE_I(ppi_line),
        .PPI_ACK_I(ppi_ack), .PPI_EOI_I(ppi_eoi), .SPI_LINE_I(spi_line), .SPI_ACK_I(spi_ack),
        .SPI_EOI_I(spi_eoi), .FWD_PPI_O(fwd_ppi), .FWD_SPI_O(fwd_spi));
    cpu_if_model i_ppi_cpu (.clk_i(clk), .rst_i(rst), .accept_i(ppi_acc), .fwd_i(fwd_ppi),
        .ack_o(ppi_ack), .eoi_o(ppi_eoi));
    cpu_if_model i_spi_cpu (.clk_i(clk), .rst_i(rst), .accept_i(spi_acc), .fwd_i(fwd_spi),
        .ack_o(spi_ack), .eoi_o(spi_eoi));

    ////////////////////////////////////////////////////////////////////////////
    // compare, verdict and hang guard
    task automatic check(input word_type got, input word_type exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // single word transfer: address phase, then data phase until hready
    task automatic bus(input logic wr, input logic [11:0] a, input word_type wd, input master_type m,
        input logic ns);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {20'h0_0000, a};
        hwrite <= wr;
        hmaster <= m;
        hnonsec <= ns;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input word_type d, input master_type m = 4'h0,
        input logic ns = 1'b0);
        bus(1'b1, a, d, m, ns);
    endtask

    task automatic chk(input logic [11:0] a, input word_type e, input master_type m = 4'h0,
        input logic ns = 1'b0);
        bus(1'b0, a, 32'h0000_0000, m, ns);
        check(rd, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = '0;
        hmaster = '0;
        hnonsec = 1'b0;
        group = '1;
        lock = 1'b0;
        sgi_pend = 32'h5A00_00A5;
        ppi_line = '0;
        spi_line = '0;
        ppi_acc = 1'b0;
        spi_acc = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // values after reset, banked software pending view
        chk(12'h180, 32'h0000_FFFF);
        chk(12'h184, 32'h0000_0000);
        chk(12'h200, 32'h0000_00A5);
        chk(12'h200, 32'h0000_5A00, 4'h1);
        chk(12'h188, 32'h0000_0000);
        // enable all, then clear some
        wr(12'h104, 32'hFFFF_FFFF);
        chk(12'h184, 32'hFFFF_FFFF);
        wr(12'h184, 32'h0000_0003);
        chk(12'h184, 32'hFFFF_FFFC);
        wr(12'h184, 32'h0000_0000);
        chk(12'h184, 32'hFFFF_FFFC);
        wr(12'h180, 32'h0000_FFFF);
        chk(12'h180, 32'h0000_FFFF);
        // per-processor copy of register zero
        wr(12'h100, 32'hFFFF_0000);
        chk(12'h180, 32'hFFFF_FFFF);
        chk(12'h180, 32'h0000_FFFF, 4'h1);
        wr(12'h180, 32'h0001_0000);
        chk(12'h180, 32'hFFFE_FFFF);
        chk(12'h180, 32'h0000_0000, 4'h5);
        // pending by write, forwarding gated by enable
        wr(12'h204, 32'h0000_0010);
        chk(12'h204, 32'h0000_0010);
        check(fwd_spi, 32'h0000_0010);
        wr(12'h184, 32'h0000_0010);
        check(fwd_spi, 32'h0000_0000);
        spi_line <= 32'h0000_0001;
        repeat (6) @(posedge clk);
        spi_line <= 32'h0000_0000;
        chk(12'h204, 32'h0000_0011);
        check(fwd_spi, 32'h0000_0000);
        wr(12'h204, 32'h0000_0011);
        chk(12'h204, 32'h0000_0011);
        wr(12'h200, 32'h0000_FFFF);
        chk(12'h200, 32'h0000_00A5);
        wr(12'h200, 32'h0002_0000, 4'h1);
        chk(12'h200, 32'h0002_5A00, 4'h1);
        chk(12'h200, 32'h0000_00A5);
        check(fwd_ppi, 32'h0000_0000);
        ppi_line <= 32'h0000_0008;
        repeat (6) @(posedge clk);
        chk(12'h200, 32'h0008_00A5);
        check(fwd_ppi, 32'h0000_0008);
        // group 0 hidden from non-secure accesses
        group[34] <= 1'b0;
        chk(12'h184, 32'hFFFF_FFE8, 4'h0, 1'b1);
        chk(12'h184, 32'hFFFF_FFEC);
        wr(12'h184, 32'h0000_0004, 4'h0, 1'b1);
        wr(12'h204, 32'h0000_0004, 4'h0, 1'b1);
        chk(12'h184, 32'hFFFF_FFEC);
        chk(12'h204, 32'h0000_0011);
        // lockdown of group 0 shared interrupts
        lock <= 1'b1;
        wr(12'h184, 32'h0000_0004);
        chk(12'h184, 32'hFFFF_FFEC);
        wr(12'h204, 32'h0000_0004);
        chk(12'h204, 32'h0000_0011);
        wr(12'h184, 32'h0000_0008);
        chk(12'h184, 32'hFFFF_FFE4);
        lock <= 1'b0;
        wr(12'h184, 32'h0000_0004);
        chk(12'h184, 32'hFFFF_FFE0);
        // registers beyond the implemented lines
        wr(12'h188, 32'hFFFF_FFFF);
        wr(12'h208, 32'hFFFF_FFFF);
        chk(12'h188, 32'h0000_0000);
        chk(12'h208, 32'h0000_0000);
        // taken by the far side, then pended again while active
        spi_acc <= 1'b1;
        wr(12'h204, 32'h0000_0020);
        repeat (4) @(posedge clk);
        spi_acc <= 1'b0;
        chk(12'h204, 32'h0000_0011);
        wr(12'h204, 32'h0000_0020);
        chk(12'h204, 32'h0000_0031);
        chk(12'h204, 32'h0000_0031);
        check({31'h0000_0000, hresp}, 32'h0000_0000);
        results();
    end
endmodule // irq_enable_pending_regs_tb
`default_nettype wire
